// ---- hw/pes_event_select.sv ----
/*
 * Event source selection for one channel of a PWM timer: three select
 * registers steer synchronised trigger and pin edges into count-up,
 * count-down and capture-A actions; capture register A lives here.
 * Assumes a classic Wishbone master on clk and a counter core that
 * presents its value on counter_value and obeys the pulse outputs.
 */
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps

// How it works
// R1: Trigger A field picks up-count edges.
// R2: Bits 3:2, 5:4, 7:6 select other triggers.
// R3: Bits 9:8 qualify pin A rise by B.
// R4: Bits 11:10..15:14 are further pin conditions.
// R5: Down register trigger A field picks edges.
// R6: Down register bits 9:8 qualify pin A.
// R7: Capture register trigger A field picks edges.
// R8: Capture register bits 9:8 qualify pin A.
// R9: All select fields read and write.
// R10: Synchronise inputs, one action per edge.
module pes_event_select
    import pes_pkg::*;
(
    // Timer clock
    input wire logic clk,
    // Asynchronous reset, active low
    input wire logic arst_n,
    // Wishbone cycle
    input wire logic wb_cyc_i,
    // Wishbone strobe
    input wire logic wb_stb_i,
    // Wishbone write enable
    input wire logic wb_we_i,
    // Wishbone byte address
    input wire logic [7:0] wb_adr_i,
    // Wishbone byte selects
    input wire logic [3:0] wb_sel_i,
    // Wishbone write data
    input wire logic [31:0] wb_dat_i,
    // Wishbone read data
    output logic [31:0] wb_dat_o,
    // Wishbone acknowledge
    output logic wb_ack_o,
    // External trigger inputs, A in bit 0
    input wire logic [EXT_N-1:0] external_trigger,
    // Channel pin A level
    input wire logic channel_pin_a,
    // Channel pin B level
    input wire logic channel_pin_b,
    // Present counter value
    input wire logic [CNT_W-1:0] counter_value,
    // Increment request, one cycle per edge
    output logic count_up,
    // Decrement request, one cycle per edge
    output logic count_down,
    // Capture strobe, one cycle per edge
    output logic capture_a,
    // Capture register A contents
    output logic [CNT_W-1:0] compare_capture_reg_a
);

    // Edge select decode for one trigger field
    function automatic logic ext_hit(
        input logic [1:0] mode,
        input logic rise,
        input logic fall
    );
        logic on_rise;
        logic on_fall;
        on_rise = (mode == EDGE_RISE) || (mode == EDGE_BOTH);
        on_fall = (mode == EDGE_FALL) || (mode == EDGE_BOTH);
        ext_hit = (on_rise && rise) || (on_fall && fall);
    endfunction

    // Condition decode for one pin edge field
    function automatic logic cond_hit(
        input logic [1:0] mode,
        input logic pin_edge,
        input logic other
    );
        logic ok;
        ok = (mode == COND_ALWAYS)
            || ((mode == COND_OTHER_LOW) && !other)
            || ((mode == COND_OTHER_HIGH) && other);
        cond_hit = pin_edge && ok;
    endfunction

    // Whole select register decode, shared by all three actions
    function automatic logic sel_hit(
        input logic [SEL_W-1:0] sel,
        input pes_in_t rise,
        input pes_in_t fall,
        input pes_in_t lvl
    );
        logic hit;
        logic [COND_N-1:0] pedge;
        logic [COND_N-1:0] other;
        hit = 1'b0;
        // Field 0 and 1 watch pin A, fields 2 and 3 watch pin B
        pedge = {fall.pin_b, rise.pin_b, fall.pin_a, rise.pin_a};
        other = {lvl.pin_a, lvl.pin_a, lvl.pin_b, lvl.pin_b};
        // Trigger fields in bit pairs 1:0 up to 7:6
        for (int i = 0; i < EXT_N; i++) begin
            hit = hit | ext_hit(sel[2*i +: 2], rise.ext[i], fall.ext[i]); // see R1 R2
        end
        // Pin fields in bit pairs 9:8 up to 15:14
        for (int j = 0; j < COND_N; j++) begin
            hit = hit | cond_hit(sel[COND_LSB + 2*j +: 2], pedge[j], other[j]); // see R3 R4
        end
        sel_hit = hit;
    endfunction

    // Raw pin and trigger levels
    pes_in_t raw;
    // First synchroniser stage
    pes_in_t sync1_q;
    // Second synchroniser stage, the usable level
    pes_in_t sync2_q;
    // Previous usable level for edge detection
    pes_in_t prev_q;
    // Rising and falling edges this cycle
    pes_in_t rise;
    pes_in_t fall;

    // Select registers, lower halves only
    logic [SEL_W-1:0] up_sel_q;
    logic [SEL_W-1:0] down_sel_q;
    logic [SEL_W-1:0] capa_sel_q;
    // Capture register A
    logic [CNT_W-1:0] ccra_q;
    // Registered action pulses
    pes_evt_t evt_q;
    pes_evt_t evt_d;

    // Bus response registers
    logic ack_q;
    logic [31:0] rdata_q;

    // Bus decode
    wire logic req = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic wr = req && wb_we_i;
    wire logic hit_up = (wb_adr_i == OFS_UP);
    wire logic hit_down = (wb_adr_i == OFS_DOWN);
    wire logic hit_capa = (wb_adr_i == OFS_CAPA);
    wire logic hit_stat = (wb_adr_i == OFS_STAT);
    wire logic hit_ccra = (wb_adr_i == OFS_CCRA);
    // Lower two byte lanes carry the select fields
    wire logic [SEL_W-1:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire logic [SEL_W-1:0] wdata = wb_dat_i[SEL_W-1:0];

    // Next values of the select registers under byte masking
    wire logic [SEL_W-1:0] up_sel_d = (up_sel_q & ~lane_mask) | (wdata & lane_mask);
    wire logic [SEL_W-1:0] down_sel_d = (down_sel_q & ~lane_mask) | (wdata & lane_mask);
    wire logic [SEL_W-1:0] capa_sel_d = (capa_sel_q & ~lane_mask) | (wdata & lane_mask);

    // Read data mux, unmapped offsets and select register upper halves read zero
    wire logic [31:0] rmux =
        hit_up ? {16'h0000, up_sel_q} :
        hit_down ? {16'h0000, down_sel_q} :
        hit_capa ? {16'h0000, capa_sel_q} :
        hit_stat ? {{26{1'b0}}, sync2_q} :
        hit_ccra ? ccra_q :
        32'h00000000;

    // Gather the inputs into one vector
    assign raw = '{pin_b: channel_pin_b, pin_a: channel_pin_a, ext: external_trigger};

    // Edges compare two settled samples only
    assign rise = sync2_q & ~prev_q; // see R10
    assign fall = ~sync2_q & prev_q; // see R10

    // Action decode from the three select registers
    assign evt_d.up = sel_hit(up_sel_q, rise, fall, sync2_q); // see R1 R3
    assign evt_d.down = sel_hit(down_sel_q, rise, fall, sync2_q); // see R5 R6
    assign evt_d.capa = sel_hit(capa_sel_q, rise, fall, sync2_q); // see R7 R8

    // Synchroniser and edge history
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= raw; // see R10
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // Action pulses, one cycle for each qualifying edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_q <= '0;
        end else begin
            evt_q <= evt_d; // see R10
        end
    end

    // Capture register A takes the counter on a capture action
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ccra_q <= CCRA_RST;
        end else if (evt_d.capa) begin
            ccra_q <= counter_value; // see R7 R8
        end
    end

    // Select register writes, taken when ack is raised
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            up_sel_q <= SEL_RST;
            down_sel_q <= SEL_RST;
            capa_sel_q <= SEL_RST;
        end else if (wr) begin
            // Only the addressed register changes
            if (hit_up) begin
                up_sel_q <= up_sel_d; // see R9
            end
            if (hit_down) begin
                down_sel_q <= down_sel_d; // see R9
            end
            if (hit_capa) begin
                capa_sel_q <= capa_sel_d; // see R9
            end
        end
    end

    // Bus answer: one wait state, ack for one cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= req;
            // Read data latched with the ack
            rdata_q <= req ? rmux : 32'h00000000; // see R9
        end
    end

    // Outputs
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign count_up = evt_q.up;
    assign count_down = evt_q.down;
    assign capture_a = evt_q.capa;
    assign compare_capture_reg_a = ccra_q;

endmodule

// ---- hw/pes_pkg.sv ----
/*
 * Package for the timer event source select block: register offsets,
 * field positions, reset values, field encodings and carrier types.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package pes_pkg;

    // Counter width seen by the capture register
    localparam int unsigned CNT_W = 32;
    // Number of external trigger inputs and pin condition fields
    localparam int unsigned EXT_N = 4;
    localparam int unsigned COND_N = 4;
    // Width of the implemented half of each select register
    localparam int unsigned SEL_W = 16;
    // Low bit of the first pin condition field
    localparam int unsigned COND_LSB = 8;
    // Bit positions of the pins in the sampled input vector
    localparam int unsigned PIN_A_BIT = 4;
    localparam int unsigned PIN_B_BIT = 5;

    // Register byte offsets
    localparam logic [7:0] OFS_UP = 8'h00;
    localparam logic [7:0] OFS_DOWN = 8'h04;
    localparam logic [7:0] OFS_CAPA = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_CCRA = 8'h10;

    // Reset values
    localparam logic [SEL_W-1:0] SEL_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CCRA_RST = 32'h00000000;

    // Edge select encoding for external trigger fields
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Condition encoding for pin edge fields
    localparam logic [1:0] COND_NEVER = 2'h0;
    localparam logic [1:0] COND_OTHER_LOW = 2'h1;
    localparam logic [1:0] COND_OTHER_HIGH = 2'h2;
    localparam logic [1:0] COND_ALWAYS = 2'h3;

    // Sampled inputs, pins above the external triggers
    typedef struct packed {
        logic pin_b;
        logic pin_a;
        logic [EXT_N-1:0] ext;
    } pes_in_t;

    // Action pulses produced per clock
    typedef struct packed {
        logic up;
        logic down;
        logic capa;
    } pes_evt_t;

endpackage

// ---- dv/pes_event_select_properties.sv ----
/* Checker for the event select block: bus answers and action pulses.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
module pes_event_select_properties
    import pes_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [EXT_N-1:0] external_trigger,
    input wire logic channel_pin_a,
    input wire logic channel_pin_b,
    input wire logic [CNT_W-1:0] counter_value,
    input wire logic count_up,
    input wire logic count_down,
    input wire logic capture_a,
    input wire logic [CNT_W-1:0] compare_capture_reg_a
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // All sampled inputs in one vector
    wire logic [5:0] in_v = {channel_pin_b, channel_pin_a, external_trigger};

    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("No ack one cycle after request");
    AST_ACK_ONCE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Ack longer than one cycle");
    AST_DAT_QUIET: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("Read data outside ack");
    AST_UP_CAUSE: assert property (count_up |-> $past(in_v, 3) != $past(in_v, 4))
        else $error("Up pulse without input edge");
    AST_DN_CAUSE: assert property (count_down |-> $past(in_v, 3) != $past(in_v, 4))
        else $error("Down pulse without input edge");
    AST_CAP_CAUSE: assert property (capture_a |-> $past(in_v, 3) != $past(in_v, 4))
        else $error("Capture without input edge");
    AST_CAP_LOAD: assert property (capture_a |-> compare_capture_reg_a == $past(counter_value))
        else $error("Capture register not loaded");
    AST_CAP_HOLD: assert property ($changed(compare_capture_reg_a) |-> capture_a)
        else $error("Capture register changed alone");
endmodule

// ---- dv/pes_far_model.sv ----
/* Far side model: trigger and pin levels plus a counter core.
   Assumes the bench sets levels just after rising clock edges. */
`timescale 1ns/10ps
module pes_far_model
    import pes_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [5:0] lvl,
    input wire pes_evt_t evt,
    output pes_in_t pins,
    output logic [CNT_W-1:0] counter_value
);
    // Counter state
    logic [CNT_W-1:0] cnt_q;
    // Levels held whole cycles so no edge is lost
    assign pins = pes_in_t'(lvl);
    assign counter_value = cnt_q;
    // Counter core obeys up and down pulses
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 32'h00001000;
        end else begin
            cnt_q <= cnt_q + CNT_W'(evt.up) - CNT_W'(evt.down);
        end
    end
endmodule

// ---- dv/pes_event_select_tb.sv ----
/* Bench for the event select block: register access and edge actions.
   Assumes the far side model and the checker beside the design. */
`timescale 1ns/10ps
module pes_event_select_tb;
    import pes_pkg::*;
    logic clk = 0;
    logic arst_n = 0;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic [7:0] adr = 0;
    logic [31:0] wdat = 0;
    logic [31:0] rdat;
    logic [5:0] lvl = 0;
    logic ack, up, dn, cap;
    pes_in_t pins;
    pes_evt_t evt;
    logic [CNT_W-1:0] cval;
    logic [CNT_W-1:0] ccra;
    logic [3:0] sel = 4'hf;
    int fails = 0;
    int n_checks = 0;
    int cnt[3];
    assign evt = '{up, dn, cap};
    always #10 clk = ~clk;
    // Tally of action pulses
    always @(posedge clk) begin
        cnt[0] += int'(up === 1'b1);
        cnt[1] += int'(dn === 1'b1);
        cnt[2] += int'(cap === 1'b1);
    end
    pes_far_model i_far (.clk(clk), .arst_n(arst_n), .lvl(lvl), .evt(evt), .pins(pins),
        .counter_value(cval));
    pes_event_select i_dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .external_trigger(pins.ext), .channel_pin_a(pins.pin_a),
        .channel_pin_b(pins.pin_b), .counter_value(cval), .count_up(up), .count_down(dn),
        .capture_a(cap), .compare_capture_reg_a(ccra));
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int k;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = rdat;
        cyc <= 0;
        stb <= 0;
        if (k >= 20) begin
            fails++;
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(0, a, 0, q);
        chk(q, e);
    endtask
    // Set one level, then let the pulse pass
    task automatic drive(input int b, input logic v);
        @(posedge clk);
        lvl[b] <= v;
        repeat (6) @(posedge clk);
    endtask
    task automatic toggle(input int b, input int r, input int e);
        cnt = '{0, 0, 0};
        drive(b, 1);
        drive(b, 0);
        chk(32'(cnt[r]), 32'(e));
        chk(32'(cnt[0] + cnt[1] + cnt[2]), 32'(e));
    endtask
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1;
        for (int r = 0; r < 3; r++) begin
            rd(8'(r * 4), 0);
            wr(8'(r * 4), 32'hffffa5c3);
            rd(8'(r * 4), 32'h0000a5c3);
            wr(8'(r * 4), 0);
        end
        rd(8'h20, 0);
        // Upper byte lane only: low byte must keep its value
        sel <= 4'h2;
        wr(OFS_DOWN, 32'h0000ffff);
        rd(OFS_DOWN, 32'h0000ff00);
        sel <= 4'hf;
        wr(OFS_DOWN, 0);
        rd(OFS_DOWN, 0);
        $display("Register test done");
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 4; i++)
                for (int m = 0; m < 4; m++) begin
                    wr(8'(r * 4), 32'(m << (2 * i)));
                    toggle(i, r, m % 2 + m / 2);
                end
            for (int m = 0; m < 4; m++)
                for (int b = 0; b < 2; b++) begin
                    wr(8'(r * 4), 32'(m << COND_LSB));
                    drive(PIN_B_BIT, b[0]);
                    toggle(PIN_A_BIT, r, int'(m == 3 || m == 1 + b));
                end
            wr(8'(r * 4), 0);
        end
        $display("Edge test done");
        drive(PIN_B_BIT, 0);
        for (int f = 1; f < 4; f++) begin
            wr(OFS_UP, 32'(3 << (COND_LSB + 2 * f)));
            toggle(f < 2 ? PIN_A_BIT : PIN_B_BIT, 0, 1);
        end
        $display("Condition test done");
        // Status shows the synchronised pin level
        wr(OFS_UP, 0);
        drive(PIN_A_BIT, 1);
        rd(OFS_STAT, 32'h00000010);
        drive(PIN_A_BIT, 0);
        rd(OFS_STAT, 0);
        // Capture takes the counter, which stands still with no selects
        wr(OFS_CAPA, 32'h00000001);
        toggle(0, 2, 1);
        chk(ccra, cval);
        rd(OFS_CCRA, cval);
        wr(OFS_CAPA, 0);
        $display("Capture test done");
        close_out();
    end
endmodule
bind pes_event_select pes_event_select_properties i_chk (.clk, .arst_n, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .external_trigger, .channel_pin_a, .channel_pin_b, .counter_value,
    .count_up, .count_down, .capture_a, .compare_capture_reg_a);
